// >>> hw/cnib_pkg.sv
// Types shared by the node-ID and bit-rate selector files.
package cnib_pkg;
  // Bit rate index: 0=10k 1=20k 2=50k 3=125k 4=250k 5=500k 6,7=1000k.
  typedef logic [3:0] cnib_rate_t;
  typedef logic [6:0] cnib_node_t;
  typedef enum logic [2:0] {
    CNIB_IDLE = 3'b001,
    CNIB_LOAD = 3'b010,
    CNIB_DONE = 3'b100
  } cnib_state_e;
endpackage

// >>> hw/cnib_rate_decode.sv
// Decoder from the stored bit-rate object code to a bit-rate index.
`timescale 1ns/10ps
`include "cnib_regs.svh"
module cnib_rate_decode
  import cnib_pkg::*;
(
  // Stored object code.
  input wire logic [7:0] rateCode,
  // Decoded index and validity.
  output cnib_rate_t rateIdx,
  output logic rateValid
);
  // Codes 0x81..0x87 map onto index 0..6 and 0x88 also onto 6; anything else falls back to 1 Mbit/s.
  always_comb begin
    if (rateCode >= `CNIB_RATE_CODE_MIN && rateCode <= `CNIB_RATE_CODE_MAX) begin // [R8]
      rateIdx = cnib_rate_t'(rateCode - `CNIB_RATE_CODE_MIN);
      if (rateIdx == 4'h7) begin
        rateIdx = 4'h6; // Both top codes give 1000 kbit/s.
      end
      rateValid = 1'b1;
    end else begin
      rateIdx = 4'h6; // [R13]
      rateValid = 1'b0;
    end
  end
endmodule

// >>> hw/cnib_regs.svh
// Register offsets, field codes, reset values and protocol codes of the node-ID and bit-rate selector.
`ifndef CNIB_REGS_SVH
`define CNIB_REGS_SVH
`define CNIB_ADDR_W 4
`define CNIB_OFF_CTRL 4'h0
`define CNIB_OFF_RATE_OBJ 4'h1
`define CNIB_OFF_NODE_OBJ 4'h2
`define CNIB_OFF_OFS_EN 4'h3
`define CNIB_OFF_OFS_VAL 4'h4
`define CNIB_OFF_STORE_SIG 4'h5
`define CNIB_OFF_STATUS 4'h6
`define CNIB_OFF_ACTIVE 4'h7
`define CNIB_OFF_LINK_CHK 4'h8
`define CNIB_OFF_LINK_ANS 4'h9
`define CNIB_OFF_LINK_STW 4'ha
`define CNIB_CTRL_RESET_COMM 0
`define CNIB_DEF_NODE 7'h01
`define CNIB_DEF_OFS_NODE 7'h7f
`define CNIB_DEF_RATE 4'h7
`define CNIB_STORE_SIGNATURE 32'h65766173
`define CNIB_RATE_CODE_MIN 8'h81
`define CNIB_RATE_CODE_MAX 8'h88
`define CNIB_SW_RECOVERY 4'h1
`define CNIB_SW_RATE_SPLIT 4'h8
`define CNIB_SDO_UPLOAD_REQ 8'h40
`define CNIB_SDO_UPLOAD_ANS 8'h4b
`define CNIB_STATUSWORD_IDX 16'h6041
`endif

// >>> hw/cnib_selector.sv
// Node-ID and bit-rate selector: object registers, storage commit, load sequence and link check.
// Functional notes
// [R1] With no other configuration, come up at node 1 and 1 Mbit/s.
// [R2] Switch at 1 forces node 1 and 1000 kbit/s.
// [R3] Commit rate and node objects only on signature 65766173 hex.
// [R4] New settings apply only after power-up or reset-communication.
// [R5] Load order: default, stored, config file, then switch overrides.
// [R6] Switch 0..7: 1 Mbit/s; 0 uses node object, 1..7 switch value.
// [R7] Switch 8..F: rate object; 8 uses node object, 9..F switch minus 8.
// [R8] Rate codes 0x81..0x86 give 10..500k; 0x87 and 0x88 give 1000k.
// [R9] Offset mode only when offset enable holds 1.
// [R10] Offset mode, switch 0: node object (default 127), 1 Mbit/s.
// [R11] Offset mode, switch 1..F: switch plus offset, rate object; switch 1 gives node 1 and 1 Mbit/s instead.
// [R12] Statusword upload request answered with 4B, index, status, zeros.
// [R13] Out-of-range rate code falls back to 1 Mbit/s.
`timescale 1ns/10ps
`include "cnib_regs.svh"
module cnib_selector
  import cnib_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Local switch and drive status.
  input wire logic [3:0] idRateSelectorSwitch,
  input wire logic [15:0] statusWord,
  // Non-volatile storage image, valid while nvPresent is high.
  input wire logic nvPresent,
  input wire logic [7:0] nvRateCode,
  input wire logic [6:0] nvNodeId,
  // Configuration file image.
  input wire logic cfgPresent,
  input wire logic [7:0] cfgRateCode,
  input wire logic [6:0] cfgNodeId,
  // Storage write request.
  output logic nvWrite,
  output logic [7:0] nvWrRateCode,
  output logic [6:0] nvWrNodeId,
  // Applied settings.
  output logic [6:0] activeNodeId,
  output logic [3:0] activeRate,
  output logic settingsValid
);
  typedef struct packed {
    cnib_state_e state;
    logic [7:0] rateObj;
    logic [6:0] storedNodeIdentifier;
    logic ofsEnable;
    logic [6:0] ofsValue;
    logic [31:0] rdData;
    logic nvWrite;
    logic [7:0] nvWrRateCode;
    logic [6:0] nvWrNodeId;
    logic [6:0] activeNodeId;
    logic [3:0] activeRate;
    logic settingsValid;
    logic [31:0] linkAns;
    logic [31:0] linkAnsHi;
    logic storedOnce;
  } cnib_state_s;

  cnib_state_s cur;
  cnib_state_s next_cur;
  cnib_rate_t rateObjIdx;
  logic rateObjValid;
  cnib_node_t mapNode;
  cnib_rate_t mapRate;

  // Index bytes of the statusword object; a sized literal cannot be part-selected directly.
  localparam logic [15:0] stwIdx = `CNIB_STATUSWORD_IDX;

  // Decoded bit-rate object feeds the switch mapping.
  cnib_rate_decode i_cnib_rate_decode (
    .rateCode(cur.rateObj),
    .rateIdx(rateObjIdx),
    .rateValid(rateObjValid)
  );

  cnib_switch_map i_cnib_switch_map (
    .switchPos(idRateSelectorSwitch),
    .nodeObj(cur.storedNodeIdentifier),
    .ofsEnable(cur.ofsEnable),
    .ofsValue(cur.ofsValue),
    .rateObjIdx(rateObjIdx),
    .nodeId(mapNode),
    .rateIdx(mapRate)
  );

  // Registered outputs.
  assign regRdData = cur.rdData;
  assign nvWrite = cur.nvWrite;
  assign nvWrRateCode = cur.nvWrRateCode;
  assign nvWrNodeId = cur.nvWrNodeId;
  assign activeNodeId = cur.activeNodeId;
  assign activeRate = cur.activeRate;
  assign settingsValid = cur.settingsValid;

  // Next-state logic: object writes, commit, load sequence and reads.
  always_comb begin
    next_cur = cur;
    next_cur.nvWrite = 1'b0;
    next_cur.rdData = 32'h0;
    case (cur.state)
      CNIB_IDLE: begin
        // Load sequence: defaults first, later sources override. [R5]
        next_cur.rateObj = `CNIB_RATE_CODE_MAX;
        next_cur.storedNodeIdentifier = cur.ofsEnable ? `CNIB_DEF_OFS_NODE : `CNIB_DEF_NODE; // [R1]
        if (nvPresent) begin
          next_cur.rateObj = nvRateCode; // [R5]
          next_cur.storedNodeIdentifier = nvNodeId;
        end
        if (cfgPresent) begin
          next_cur.rateObj = cfgRateCode; // [R5]
          next_cur.storedNodeIdentifier = cfgNodeId;
        end
        next_cur.state = CNIB_LOAD;
      end
      CNIB_LOAD: begin
        // Switch mapping is the last source and is latched here only. [R4]
        next_cur.activeNodeId = mapNode; // [R5]
        next_cur.activeRate = mapRate;
        next_cur.settingsValid = 1'b1;
        next_cur.state = CNIB_DONE;
      end
      CNIB_DONE: begin
        next_cur.state = CNIB_DONE;
      end
      default: begin
        next_cur.state = CNIB_IDLE;
      end
    endcase
    if (regWrite && cur.state == CNIB_DONE) begin
      case (regAddr)
        `CNIB_OFF_CTRL: begin
          if (regWrData[`CNIB_CTRL_RESET_COMM]) begin
            next_cur.state = CNIB_IDLE; // [R4]
            next_cur.settingsValid = 1'b0;
          end
        end
        `CNIB_OFF_RATE_OBJ: next_cur.rateObj = regWrData[7:0];
        `CNIB_OFF_NODE_OBJ: next_cur.storedNodeIdentifier = regWrData[6:0];
        `CNIB_OFF_OFS_EN: next_cur.ofsEnable = (regWrData[7:0] == 8'h01); // [R9]
        `CNIB_OFF_OFS_VAL: next_cur.ofsValue = regWrData[6:0];
        `CNIB_OFF_STORE_SIG: begin
          if (regWrData == `CNIB_STORE_SIGNATURE) begin
            next_cur.nvWrite = 1'b1; // [R3]
            next_cur.nvWrRateCode = cur.rateObj;
            next_cur.nvWrNodeId = cur.storedNodeIdentifier;
            next_cur.storedOnce = 1'b1;
          end
        end
        `CNIB_OFF_LINK_CHK: begin
          // Expedited upload of statusword index 0 is the link check. [R12]
          if (regWrData == {`CNIB_SDO_UPLOAD_REQ, stwIdx[7:0], stwIdx[15:8], 8'h00}) begin
            next_cur.linkAns = {`CNIB_SDO_UPLOAD_ANS, stwIdx[7:0], stwIdx[15:8], 8'h00}; // [R12]
            next_cur.linkAnsHi = {statusWord[7:0], statusWord[15:8], 16'h0000};
          end else begin
            next_cur.linkAns = 32'h0;
            next_cur.linkAnsHi = 32'h0;
          end
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `CNIB_OFF_RATE_OBJ: next_cur.rdData = {24'h0, cur.rateObj};
        `CNIB_OFF_NODE_OBJ: next_cur.rdData = {25'h0, cur.storedNodeIdentifier};
        `CNIB_OFF_OFS_EN: next_cur.rdData = {31'h0, cur.ofsEnable};
        `CNIB_OFF_OFS_VAL: next_cur.rdData = {25'h0, cur.ofsValue};
        `CNIB_OFF_STATUS: next_cur.rdData = {27'h0, cur.storedOnce, rateObjValid, cur.state};
        `CNIB_OFF_ACTIVE: next_cur.rdData = {20'h0, cur.settingsValid, cur.activeRate, cur.activeNodeId};
        `CNIB_OFF_LINK_ANS: next_cur.rdData = cur.linkAns;
        `CNIB_OFF_LINK_STW: next_cur.rdData = cur.linkAnsHi;
        default: next_cur.rdData = 32'h0;
      endcase
    end
  end

  // State register; reset holds defaults until the load sequence runs.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur.state <= CNIB_IDLE;
      cur.rateObj <= `CNIB_RATE_CODE_MAX;
      cur.storedNodeIdentifier <= `CNIB_DEF_NODE;
      cur.ofsEnable <= 1'b0;
      cur.ofsValue <= 7'h00;
      cur.rdData <= 32'h0;
      cur.nvWrite <= 1'b0;
      cur.nvWrRateCode <= 8'h00;
      cur.nvWrNodeId <= 7'h00;
      cur.activeNodeId <= `CNIB_DEF_NODE; // [R1]
      cur.activeRate <= `CNIB_DEF_RATE;
      cur.settingsValid <= 1'b0;
      cur.linkAns <= 32'h0;
      cur.linkAnsHi <= 32'h0;
      cur.storedOnce <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // Checks kept beside the logic.
  // Storage commit: only the signature write, and it carries the objects as they stood.
  a_commit_needs_sig: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
    nvWrite |-> $past(regWrite) && $past(regAddr) == `CNIB_OFF_STORE_SIG
    && $past(regWrData) == `CNIB_STORE_SIGNATURE)
    else $error("Storage write without signature.");
  a_commit_image: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
    nvWrite |-> nvWrRateCode == $past(cur.rateObj) && nvWrNodeId == $past(cur.storedNodeIdentifier))
    else $error("Committed image differs from objects.");

  // Applied settings move only through a reset-communication or power-up reload.
  a_active_held: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
    (cur.state == CNIB_DONE && next_cur.state == CNIB_DONE) |=> $stable(activeNodeId) && $stable(activeRate))
    else $error("Settings changed without reset.");
  a_reset_comm_drop: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
    (cur.state == CNIB_DONE && regWrite && regAddr == `CNIB_OFF_CTRL && regWrData[`CNIB_CTRL_RESET_COMM])
    |=> !settingsValid)
    else $error("Reset-communication did not drop settings.");
  a_reset_comm_back: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
    (cur.state == CNIB_DONE && regWrite && regAddr == `CNIB_OFF_CTRL && regWrData[`CNIB_CTRL_RESET_COMM])
    |=> ##2 settingsValid)
    else $error("Reset-communication did not reload settings.");

  // Switch mapping as latched at the load step.
  a_recovery_sw: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
    (cur.state == CNIB_LOAD && idRateSelectorSwitch == 4'h1) |=> activeNodeId == 7'h01 && activeRate == 4'h6)
    else $error("Recovery switch not honoured.");
  a_low_sw_rate: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    (cur.state == CNIB_LOAD && !cur.ofsEnable && idRateSelectorSwitch < 4'h8) |=> activeRate == 4'h6)
    else $error("Low switch rate not 1 Mbit/s.");
  a_low_sw_node: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    (cur.state == CNIB_LOAD && !cur.ofsEnable && idRateSelectorSwitch != 4'h0 && idRateSelectorSwitch < 4'h8)
    |=> activeNodeId == {3'h0, $past(idRateSelectorSwitch)})
    else $error("Low switch node wrong.");
  a_zero_sw_node: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    (cur.state == CNIB_LOAD && idRateSelectorSwitch == 4'h0) |=> activeNodeId == $past(cur.storedNodeIdentifier))
    else $error("Switch zero node not from object.");
  a_high_sw_node: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
    (cur.state == CNIB_LOAD && !cur.ofsEnable && idRateSelectorSwitch > 4'h8)
    |=> activeNodeId == {3'h0, 4'($past(idRateSelectorSwitch) - 4'h8)})
    else $error("High switch node wrong.");
  a_eight_sw_node: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
    (cur.state == CNIB_LOAD && !cur.ofsEnable && idRateSelectorSwitch == 4'h8)
    |=> activeNodeId == $past(cur.storedNodeIdentifier))
    else $error("Switch eight node not from object.");
  a_high_sw_rate: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
    (cur.state == CNIB_LOAD && !cur.ofsEnable && idRateSelectorSwitch >= 4'h8) |=> activeRate == $past(rateObjIdx))
    else $error("High switch rate not from object.");

  // Rate object decoding.
  a_rate_low_codes: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
    (cur.rateObj >= 8'h81 && cur.rateObj <= 8'h86) |-> rateObjIdx == cur.rateObj[3:0] - 4'h1)
    else $error("Rate code decoded wrong.");
  a_rate_top_codes: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
    (cur.rateObj == 8'h87 || cur.rateObj == 8'h88) |-> rateObjIdx == 4'h6)
    else $error("Top rate codes not 1000 kbit/s.");
  a_rate_fallback: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
    !rateObjValid |-> rateObjIdx == 4'h6)
    else $error("Invalid rate code not at 1 Mbit/s.");

  // Offset mode mapping.
  a_ofs_zero_rate: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
    (cur.state == CNIB_LOAD && cur.ofsEnable && idRateSelectorSwitch == 4'h0) |=> activeRate == 4'h6)
    else $error("Offset switch zero rate not 1 Mbit/s.");
  a_offset_node: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
    (cur.state == CNIB_LOAD && cur.ofsEnable && idRateSelectorSwitch > 4'h1)
    |=> activeNodeId == 7'($past(cur.ofsValue) + {3'h0, $past(idRateSelectorSwitch)}))
    else $error("Offset node wrong.");
  a_offset_rate: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
    (cur.state == CNIB_LOAD && cur.ofsEnable && idRateSelectorSwitch > 4'h1) |=> activeRate == $past(rateObjIdx))
    else $error("Offset rate not from object.");

  // Load order of the object sources.
  a_load_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
    (cur.state == CNIB_IDLE && cfgPresent) |=> cur.rateObj == $past(cfgRateCode))
    else $error("Config file not overriding.");
  a_nv_load: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
    (cur.state == CNIB_IDLE && nvPresent && !cfgPresent)
    |=> cur.rateObj == $past(nvRateCode) && cur.storedNodeIdentifier == $past(nvNodeId))
    else $error("Stored image not loaded.");
  a_default_load: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    (cur.state == CNIB_IDLE && !cur.ofsEnable && !nvPresent && !cfgPresent)
    |=> cur.rateObj == 8'h88 && cur.storedNodeIdentifier == 7'h01)
    else $error("Default objects not loaded.");
  a_default_up: assert property (@(posedge clk_sys) // [R1]
    !rst_n |=> activeNodeId == 7'h01 && settingsValid == 1'b0)
    else $error("Reset defaults wrong.");

  // Link check answer and the one-cycle read data.
  a_link_answer: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
    (cur.state == CNIB_DONE && regWrite && regAddr == `CNIB_OFF_LINK_CHK && regWrData == 32'h40416000)
    |=> cur.linkAns == 32'h4b416000)
    else $error("Link check answer wrong.");
  a_link_status: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
    (cur.state == CNIB_DONE && regWrite && regAddr == `CNIB_OFF_LINK_CHK && regWrData == 32'h40416000)
    |=> cur.linkAnsHi == {$past(statusWord[7:0]), $past(statusWord[15:8]), 16'h0000})
    else $error("Link check status bytes wrong.");
  a_read_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(regRead) |-> regRdData == 32'h0)
    else $error("Read data outside its cycle.");
endmodule

// >>> hw/cnib_switch_map.sv
// Mapping of the selector switch and stored objects to node identifier and bit rate.
`timescale 1ns/10ps
`include "cnib_regs.svh"
module cnib_switch_map
  import cnib_pkg::*;
(
  // Switch and objects.
  input wire logic [3:0] switchPos,
  input wire logic [6:0] nodeObj,
  input wire logic ofsEnable,
  input wire logic [6:0] ofsValue,
  input wire cnib_rate_t rateObjIdx,
  // Result.
  output cnib_node_t nodeId,
  output cnib_rate_t rateIdx
);
  // Switch picks node and rate, taking the node object at 0 and 8 and the rate object at 8..F or offset 2..F; offset mode changes the mapping.
  always_comb begin
    if (switchPos == `CNIB_SW_RECOVERY) begin
      nodeId = `CNIB_DEF_NODE; // [R2]
      rateIdx = 4'h6; // [R2]
    end else if (ofsEnable) begin // [R9]
      if (switchPos == 4'h0) begin
        nodeId = nodeObj; // [R10]
        rateIdx = 4'h6; // [R10]
      end else begin
        nodeId = 7'(ofsValue + {3'h0, switchPos}); // [R11]
        rateIdx = rateObjIdx; // [R11]
      end
    end else if (switchPos < `CNIB_SW_RATE_SPLIT) begin
      nodeId = (switchPos == 4'h0) ? nodeObj : {3'h0, switchPos}; // [R6]
      rateIdx = 4'h6; // [R6]
    end else begin
      nodeId = (switchPos == `CNIB_SW_RATE_SPLIT) ? nodeObj : {3'h0, 4'(switchPos - 4'h8)}; // [R7]
      rateIdx = rateObjIdx; // [R7]
    end
  end
endmodule

// >>> tb/cnib_nv_store_model.sv
// Model of the non-volatile store that keeps the committed rate and node objects.
`timescale 1ns/10ps
module cnib_nv_store_model (
  // Clock.
  input wire logic clk_sys,
  // Commit from the selector.
  input wire logic nvWrite,
  input wire logic [7:0] nvWrRateCode,
  input wire logic [6:0] nvWrNodeId,
  // Stored image.
  output logic nvPresent,
  output logic [7:0] nvRateCode,
  output logic [6:0] nvNodeId,
  output logic [7:0] storeCount
);
  // Empty at power-up; the data lines hold junk so a read of an absent image cannot pass by luck.
  initial begin
    nvPresent = 1'b0;
    nvRateCode = 8'h5a;
    nvNodeId = 7'h2a;
    storeCount = 8'h00;
  end
  // The image changes only on a commit pulse, never on plain object writes.
  always @(posedge clk_sys) begin
    if (nvWrite === 1'b1) begin
      nvPresent <= 1'b1;
      nvRateCode <= nvWrRateCode;
      nvNodeId <= nvWrNodeId;
      storeCount <= storeCount + 8'h01;
    end
  end
endmodule

// >>> tb/tb_can_node_id_baud_selector.sv
// Self-checking bench of the node-ID and bit-rate selector.
`timescale 1ns/10ps
module tb_can_node_id_baud_selector;
  import cnib_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic [3:0] switchPos = 4'h0;
  logic [15:0] statusWord = 16'h0;
  logic nvPresent, nvWrite, settingsValid;
  logic [7:0] nvRateCode, nvWrRateCode, storeCount;
  logic [6:0] nvNodeId, nvWrNodeId, ofsVal;
  logic [6:0] actNode;
  logic [3:0] actRate;
  logic cfgPresent = 1'b0;
  logic [7:0] cfgRateCode = 8'h0;
  logic [6:0] cfgNodeId = 7'h0;
  logic rdSeen = 1'b0;
  logic [31:0] rnd = 32'h7;
  logic [31:0] expQ[$];
  logic actQ[$];
  logic [14:0] nvQ[$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  cnib_selector i_cnib_selector (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .idRateSelectorSwitch(switchPos),
    .statusWord(statusWord), .nvPresent(nvPresent), .nvRateCode(nvRateCode), .nvNodeId(nvNodeId),
    .cfgPresent(cfgPresent), .cfgRateCode(cfgRateCode), .cfgNodeId(cfgNodeId), .nvWrite(nvWrite),
    .nvWrRateCode(nvWrRateCode), .nvWrNodeId(nvWrNodeId), .activeNodeId(actNode), .activeRate(actRate),
    .settingsValid(settingsValid));
  cnib_nv_store_model i_cnib_nv_store_model (.clk_sys(clk_sys), .nvWrite(nvWrite),
    .nvWrRateCode(nvWrRateCode), .nvWrNodeId(nvWrNodeId), .nvPresent(nvPresent), .nvRateCode(nvRateCode),
    .nvNodeId(nvNodeId), .storeCount(storeCount));

  // A 10 MHz clock.
  always #50 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Codes outside the table fall back to the fixed 1 Mbit/s index.
  function automatic logic [3:0] rateOf(input logic [7:0] c);
    return (c >= 8'h81 && c <= 8'h88) ? c[3:0] - 4'h1 : 4'h7;
  endfunction

  // Expected active word from switch, offset mode and loaded objects.
  function automatic logic [31:0] act(input logic [3:0] s, input logic oe, input logic [6:0] ov, input logic [6:0] nd,
    input logic [3:0] ro);
    logic [6:0] n;
    logic [3:0] r;
    r = 4'h7;
    n = nd;
    if (s == 4'h1) n = 7'h01;
    else if (oe) begin
      if (s != 4'h0) begin
        n = ov + {3'h0, s};
        r = ro;
      end
    end else if (s >= 4'h8) begin
      r = ro;
      if (s != 4'h8) n = {3'h0, s - 4'h8};
    end else if (s != 4'h0) n = {3'h0, s};
    return {20'h0, 1'b1, r, n};
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic isAct);
    expQ.push_back(e);
    actQ.push_back(isAct);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic waitValid;
    int k;
    k = 0;
    #1;
    while (settingsValid !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask

  task automatic resetComm;
    wr(4'h0, 32'h1);
    repeat (2) @(posedge clk_sys);
    waitValid();
    @(posedge clk_sys);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watcher: read data stand only in the cycle after the strobe; both rate indices for 1000k count as one.
  always @(posedge clk_sys) begin
    logic [31:0] e;
    logic [31:0] g;
    logic [14:0] n;
    rdSeen <= regRead;
    if (rdSeen) begin
      e = expQ.pop_front();
      g = regRdData;
      if (actQ.pop_front()) begin
        if (g[10:7] === 4'h6) g[10:7] = 4'h7;
        if (e[10:7] === 4'h6) e[10:7] = 4'h7;
        cmp({20'h0, settingsValid, (actRate === 4'h6) ? 4'h7 : actRate, actNode}, e);
      end
      cmp(g, e);
    end
    if (nvWrite === 1'b1) begin
      n = nvQ.size() ? nvQ.pop_front() : 15'h7fff;
      cmp({17'h0, nvWrRateCode, nvWrNodeId}, {17'h0, n});
    end
  end

  // A hang is cut short well above the expected run of under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    waitValid();
    rd(4'h7, 32'hb81, 1'b1);
    rd(4'hf, 32'h0, 1'b0);
    $display("test power-up done");
    wr(4'h1, 32'h84);
    wr(4'h2, 32'h15);
    wr(4'h5, 32'h65766172);
    rd(4'h7, 32'hb81, 1'b1);
    nvQ.push_back({8'h84, 7'h15});
    wr(4'h5, 32'h65766173);
    switchPos <= 4'h8;
    resetComm();
    cmp({24'h0, storeCount}, 32'h1);
    rd(4'h6, 32'h1c, 1'b0);
    rd(4'h7, act(4'h8, 1'b0, 7'h0, 7'h15, 4'h3), 1'b1);
    $display("test store done");
    cfgPresent <= 1'b1;
    cfgNodeId <= 7'h22;
    for (int c = 8'h80; c <= 8'h89; c++) begin
      cfgRateCode <= c[7:0];
      resetComm();
      rd(4'h7, act(4'h8, 1'b0, 7'h0, 7'h22, rateOf(c[7:0])), 1'b1);
    end
    $display("test rate codes done");
    cfgRateCode <= 8'h83;
    for (int m = 0; m < 2; m++) begin
      rnd = xs(rnd);
      ofsVal = rnd[6:0];
      wr(4'h3, m ? 32'h1 : 32'h2);
      wr(4'h4, {25'h0, ofsVal});
      for (int s = 0; s < 16; s++) begin
        switchPos <= s[3:0];
        resetComm();
        rd(4'h7, act(s[3:0], m[0], ofsVal, 7'h22, 4'h2), 1'b1);
      end
    end
    $display("test switch map done");
    rnd = xs(rnd);
    statusWord <= rnd[15:0];
    wr(4'h8, 32'h40416000);
    rd(4'h9, 32'h4b416000, 1'b0);
    rd(4'ha, {rnd[7:0], rnd[15:8], 16'h0}, 1'b0);
    wr(4'h8, 32'h40416001);
    rd(4'h9, 32'h0, 1'b0);
    $display("test link check done");
    repeat (4) @(posedge clk_sys);
    stop_test();
  end
endmodule
